// File: verilog/ises_cfg.svh
// Constants for the interrupt source status event aggregation block
`ifndef ISES_CFG_SVH
`define ISES_CFG_SVH

// ==========================================================================
// Register offsets
`define ISES_STATUS_ADDR 8'h00

// ==========================================================================
// Field positions in the interrupt source status register
`define ISES_BIT_BUF 5
`define ISES_BIT_OT 4
`define ISES_BIT_WT 3
`define ISES_BIT_ORIENT 2

// ==========================================================================
// Buffer mode select codes
`define ISES_BUF_MODE_OFF 2'h0
`define ISES_BUF_MODE_TRIG 2'h2

// ==========================================================================
// Reset values
`define ISES_FLAG_RESET 1'b0
`define ISES_STATUS_RESET 8'h00

`endif

// File: verilog/ises_pkg.sv
// Types for the interrupt source status event aggregation block
package ises_pkg;

  typedef logic [1:0] ises_buf_mode_t;

  // Index of each event flag in the flag vector
  typedef enum logic [1:0] {
    ISES_EV_OT = 2'b00,
    ISES_EV_WT = 2'b01,
    ISES_EV_ORIENT = 2'b10
  } ises_event_t;

endpackage

// File: verilog/ises_event_flag.sv
// One event flag: follows its condition, or latches until a clearing read
`include "ises_cfg.svh"

module ises_event_flag (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic latch_enable_in,
  input wire logic condition_in,
  input wire logic clear_in,
  output logic flag_out
);

  // ========================================================================
  // Flag storage
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flag_out <= `ISES_FLAG_RESET;
    end else if (latch_enable_in) begin
      // Set wins over a clear in the same cycle, so no event is lost
      flag_out <= (flag_out & ~clear_in) | condition_in;
    end else begin
      flag_out <= condition_in;
    end
  end

endmodule

// File: verilog/ises_top.sv
// Interrupt source status bits 5 to 2: buffer, threshold and orientation events
`include "ises_cfg.svh"

module ises_top
  import ises_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [1:0] buffer_mode_in,
  input wire logic buffer_watermark_flag_in,
  input wire logic buffer_overflow_flag_in,
  input wire logic buffer_gate_error_in,
  input wire logic buffer_int_enable_in,
  input wire logic buffer_int_route_in,
  input wire logic outside_threshold_condition_in,
  input wire logic within_threshold_condition_in,
  input wire logic outside_threshold_latch_enable_in,
  input wire logic within_threshold_latch_enable_in,
  input wire logic new_orientation_indicator_in,
  input wire logic orientation_change_in,
  input wire logic read_detector_source_one_in,
  input wire logic read_detector_source_two_in,
  input wire logic read_orientation_status_in,
  output logic [7:0] interrupt_source_status_out,
  output logic [1:0] buffer_status_out,
  output logic system_mode_gate_error_out,
  output logic outside_threshold_active_out,
  output logic within_threshold_active_out,
  output logic orientation_change_event_out,
  output logic interrupt_pin_one_out,
  output logic interrupt_pin_two_out
);

  // ========================================================================
  // Decoding helpers
  function automatic logic buf_enabled(input ises_buf_mode_t mode);
    buf_enabled = (mode != `ISES_BUF_MODE_OFF);
  endfunction

  function automatic logic buf_triggered(input ises_buf_mode_t mode);
    buf_triggered = (mode == `ISES_BUF_MODE_TRIG);
  endfunction

  // ========================================================================
  // Event flags: outside, within, orientation
  logic [2:0] latch_en;
  logic [2:0] cond;
  logic [2:0] clear;
  logic [2:0] flags;

  assign latch_en[ISES_EV_OT] = outside_threshold_latch_enable_in;
  assign latch_en[ISES_EV_WT] = within_threshold_latch_enable_in;
  // Orientation event always latches until its status read
  assign latch_en[ISES_EV_ORIENT] = 1'b1;
  assign cond[ISES_EV_OT] = outside_threshold_condition_in;
  assign cond[ISES_EV_WT] = within_threshold_condition_in;
  assign cond[ISES_EV_ORIENT] = new_orientation_indicator_in & orientation_change_in;
  assign clear[ISES_EV_OT] = read_detector_source_one_in;
  assign clear[ISES_EV_WT] = read_detector_source_two_in;
  assign clear[ISES_EV_ORIENT] = read_orientation_status_in;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flag
      ises_event_flag u_flag (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .latch_enable_in(latch_en[gi]),
        .condition_in(cond[gi]),
        .clear_in(clear[gi]),
        .flag_out(flags[gi])
      );
    end
  endgenerate

  // ========================================================================
  // Buffer event summary
  logic buf_summary;
  logic next_buf_summary;

  // Watermark still reported in status, but a trigger must not interrupt
  assign next_buf_summary = buf_enabled(buffer_mode_in) &
    (buffer_overflow_flag_in | buffer_gate_error_in |
     (buffer_watermark_flag_in & ~buf_triggered(buffer_mode_in)));

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      buf_summary <= 1'b0;
    end else begin
      buf_summary <= next_buf_summary;
    end
  end

  // ========================================================================
  // Buffer and system mode status mirrors
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      buffer_status_out <= 2'h0;
      system_mode_gate_error_out <= 1'b0;
    end else begin
      buffer_status_out <= {buffer_overflow_flag_in, buffer_watermark_flag_in};
      system_mode_gate_error_out <= buffer_gate_error_in;
    end
  end

  // ========================================================================
  // External interrupt pins for the buffer event
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      interrupt_pin_one_out <= 1'b0;
      interrupt_pin_two_out <= 1'b0;
    end else begin
      interrupt_pin_one_out <= next_buf_summary & buffer_int_enable_in & ~buffer_int_route_in;
      interrupt_pin_two_out <= next_buf_summary & buffer_int_enable_in & buffer_int_route_in;
    end
  end

  // ========================================================================
  // Register image; owned bits come straight from flip-flops, unowned bits read zero
  always_comb begin
    interrupt_source_status_out = `ISES_STATUS_RESET;
    interrupt_source_status_out[`ISES_BIT_BUF] = buf_summary;
    interrupt_source_status_out[`ISES_BIT_OT] = flags[ISES_EV_OT];
    interrupt_source_status_out[`ISES_BIT_WT] = flags[ISES_EV_WT];
    interrupt_source_status_out[`ISES_BIT_ORIENT] = flags[ISES_EV_ORIENT];
  end

  assign outside_threshold_active_out = flags[ISES_EV_OT];
  assign within_threshold_active_out = flags[ISES_EV_WT];
  assign orientation_change_event_out = flags[ISES_EV_ORIENT];

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  property p_buf_summary;
    1'b1 |=> buf_summary == $past(buf_enabled(buffer_mode_in) && (buffer_overflow_flag_in ||
      buffer_gate_error_in || (buffer_watermark_flag_in && !buf_triggered(buffer_mode_in))));
  endproperty
  a_buf_summary: assert property (p_buf_summary) else $error("buffer summary mismatch");

  property p_buf_off;
    buffer_mode_in == `ISES_BUF_MODE_OFF |=> !interrupt_source_status_out[`ISES_BIT_BUF];
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffer summary set while disabled");

  property p_trig_wmrk;
    buf_triggered(buffer_mode_in) && buffer_watermark_flag_in && !buffer_overflow_flag_in &&
      !buffer_gate_error_in |=> !buf_summary && buffer_status_out[0] && !interrupt_pin_one_out;
  endproperty
  a_trig_wmrk: assert property (p_trig_wmrk) else $error("triggered watermark interrupted");

  property p_full_pin;
    buf_enabled(buffer_mode_in) && buffer_overflow_flag_in && buffer_int_enable_in
      |=> buf_summary && (interrupt_pin_one_out != interrupt_pin_two_out) &&
      (interrupt_pin_two_out == $past(buffer_int_route_in));
  endproperty
  a_full_pin: assert property (p_full_pin) else $error("full buffer did not reach its pin");

  property p_ot_copy;
    !outside_threshold_latch_enable_in |=> interrupt_source_status_out[`ISES_BIT_OT] ==
      $past(outside_threshold_condition_in) && outside_threshold_active_out ==
      interrupt_source_status_out[`ISES_BIT_OT];
  endproperty
  a_ot_copy: assert property (p_ot_copy) else $error("outside bit not a copy");

  property p_ot_latch;
    outside_threshold_latch_enable_in && outside_threshold_active_out && !read_detector_source_one_in
      |=> outside_threshold_active_out;
  endproperty
  a_ot_latch: assert property (p_ot_latch) else $error("latched outside flag dropped");

  property p_wt_copy;
    !within_threshold_latch_enable_in ##1 !within_threshold_latch_enable_in
      |-> interrupt_source_status_out[`ISES_BIT_WT] == $past(within_threshold_condition_in);
  endproperty
  a_wt_copy: assert property (p_wt_copy) else $error("within bit not a copy");

  property p_wt_clear;
    within_threshold_latch_enable_in && read_detector_source_two_in && !within_threshold_condition_in
      |=> !interrupt_source_status_out[`ISES_BIT_WT];
  endproperty
  a_wt_clear: assert property (p_wt_clear) else $error("within flag not cleared by read");

  property p_orient_set;
    new_orientation_indicator_in && orientation_change_in |=> orientation_change_event_out [*1];
  endproperty
  a_orient_set: assert property (p_orient_set) else $error("orientation event missed");

  property p_orient_clear;
    read_orientation_status_in && !(new_orientation_indicator_in && orientation_change_in)
      |=> !interrupt_source_status_out[`ISES_BIT_ORIENT];
  endproperty
  a_orient_clear: assert property (p_orient_clear) else $error("orientation read did not clear");

  property p_status;
    1'b1 |=> buffer_status_out == $past({buffer_overflow_flag_in, buffer_watermark_flag_in}) &&
      system_mode_gate_error_out == $past(buffer_gate_error_in);
  endproperty
  a_status: assert property (p_status) else $error("buffer status mirror wrong");

  c_buf_pin_two: cover property (buf_summary && interrupt_pin_two_out);
  c_ot_latched_clear: cover property (outside_threshold_active_out && outside_threshold_latch_enable_in
    && read_detector_source_one_in ##1 !outside_threshold_active_out);
  c_orient_set_clear_same: cover property (read_orientation_status_in && orientation_change_in &&
    new_orientation_indicator_in ##1 orientation_change_event_out);

endmodule

// File: sim/ises_host_model.sv
// Host partner model: issues one-cycle register read strobes
`include "ises_cfg.svh"

module ises_host_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [1:0] buffer_mode_in,
  input wire logic outside_flag_in,
  input wire logic within_flag_in,
  input wire logic orientation_flag_in,
  output logic read_detector_source_one_out,
  output logic read_detector_source_two_out,
  output logic read_orientation_status_out
);
  timeunit 1ns;
  timeprecision 100ps;
  integer seed;
  logic [31:0] h;
  logic watch;
  // ==========================================
  // Read strobes, sparse, changed just after the edge
  initial begin
    seed = 32'h5D3C;
    read_detector_source_one_out = 1'b0;
    read_detector_source_two_out = 1'b0;
    read_orientation_status_out = 1'b0;
    forever begin
      @(posedge clk_in);
      #1;
      h = $random(seed);
      // Triggered buffer gives no watermark interrupt, so the host polls events then
      watch = (buffer_mode_in == `ISES_BUF_MODE_TRIG) && h[24];
      read_detector_source_one_out = !reset_in && ((h[20] & h[21] & h[22]) | (outside_flag_in & watch));
      read_detector_source_two_out = !reset_in && ((h[25] & h[26] & h[27]) | (within_flag_in & watch));
      read_orientation_status_out = !reset_in && ((h[28] & h[29]) | (orientation_flag_in & watch));
    end
  end
endmodule

// File: sim/tb.sv
// Self-checking bench for the status event aggregation block
`include "ises_cfg.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] mode = 2'h0;
  logic wm = 1'b0, ovf = 1'b0, gate = 1'b0, ien = 1'b0, route = 1'b0;
  logic otc = 1'b0, wtc = 1'b0, otle = 1'b0, wtle = 1'b0, newo = 1'b0, chg = 1'b0;
  wire logic rd1, rd2, rdo;
  logic [7:0] status;
  logic [1:0] bstat;
  logic gerr, ot, wt, ori, p1, p2;
  integer seed, i, cycles = 0, miscompares = 0, checks_done = 0;
  integer m_ot = 0, m_wt = 0, m_or = 0, e_sum;
  logic [31:0] r;
  logic s1, s2, so;
  logic [7:0] e_stat;

  ises_top u_ises_top (.clk_in(clk_in), .reset_in(reset_in), .buffer_mode_in(mode),
    .buffer_watermark_flag_in(wm), .buffer_overflow_flag_in(ovf), .buffer_gate_error_in(gate),
    .buffer_int_enable_in(ien), .buffer_int_route_in(route), .outside_threshold_condition_in(otc),
    .within_threshold_condition_in(wtc), .outside_threshold_latch_enable_in(otle),
    .within_threshold_latch_enable_in(wtle), .new_orientation_indicator_in(newo),
    .orientation_change_in(chg), .read_detector_source_one_in(rd1), .read_detector_source_two_in(rd2),
    .read_orientation_status_in(rdo), .interrupt_source_status_out(status), .buffer_status_out(bstat),
    .system_mode_gate_error_out(gerr), .outside_threshold_active_out(ot),
    .within_threshold_active_out(wt), .orientation_change_event_out(ori),
    .interrupt_pin_one_out(p1), .interrupt_pin_two_out(p2));

  ises_host_model u_ises_host_model (.clk_in(clk_in), .reset_in(reset_in), .buffer_mode_in(mode),
    .outside_flag_in(ot), .within_flag_in(wt), .orientation_flag_in(ori),
    .read_detector_source_one_out(rd1), .read_detector_source_two_out(rd2),
    .read_orientation_status_out(rdo));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // Hang guard, well above the 4000-cycle run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      end_sim;
    end
  end

  // ==========================================
  // Random stimulus, one-cycle-latency reference model
  initial begin
    seed = 32'h5D3C;
    repeat (8) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    for (i = 0; i < 4000; i++) begin
      @(posedge clk_in);
      // Strobes as the design took them, before the host model moves them
      {s1, s2, so} = {rd1, rd2, rdo};
      #1;
      if (reset_in) begin
        {m_ot, m_wt, m_or, e_sum} = 0;
      end else begin
        e_sum = (mode != `ISES_BUF_MODE_OFF) && (ovf || gate || (wm && mode != `ISES_BUF_MODE_TRIG));
        m_ot = otc || (otle && m_ot && !s1);
        m_wt = wtc || (wtle && m_wt && !s2);
        m_or = (newo && chg) || (m_or && !so);
      end
      e_stat = 8'((e_sum << `ISES_BIT_BUF) | (m_ot << `ISES_BIT_OT)
        | (m_wt << `ISES_BIT_WT) | (m_or << `ISES_BIT_ORIENT));
      check("status", status, e_stat);
      check("outside_flag", ot, m_ot);
      check("within_flag", wt, m_wt);
      check("orientation_flag", ori, m_or);
      check("pin_one", p1, e_sum && ien && !route && !reset_in);
      check("pin_two", p2, e_sum && ien && route && !reset_in);
      check("buffer_status", bstat, reset_in ? 0 : {ovf, wm});
      check("gate_error", gerr, gate && !reset_in);
      // Second reset in mid-run
      reset_in = (i >= 1500 && i < 1503);
      r = $random(seed);
      mode = r[1:0];
      wm = r[2];
      ovf = r[3] & r[4];
      gate = r[5] & r[6] & r[7];
      ien = r[8];
      route = r[9];
      otc = r[10] & r[11];
      wtc = r[12] & r[13];
      newo = r[14];
      chg = r[15] & r[16];
      if (i % 64 == 0) begin
        otle = r[17];
        wtle = r[18];
      end
    end
    end_sim;
  end
endmodule
